/* File: design/pmc_ctrl.sv */
// perf monitor control register with cycle tally and event counters
//
// Functional notes
// - read-only five-bit count of event counters
// - lower levels read hyp_counter_limit as count
// - wide_overflow_sel picks 32 or 64-bit wrap
// - prohibit_stop_bit halts cycle tally when prohibited
// - export bit gates event export, cleared on reset
// - export bit never affects overflow signalling
// - divider bit counts cycles once per 64 clocks
// - wide overflow forces per-clock cycle counting
// - cycle-reset strobe clears tally, reads zero
// - cycle strobe leaves cycle overflow flag alone
// - event-reset strobe zeroes accessible event counters
// - lower levels spare counters at or above limit while hyp_enabled is set
// - hyp-level event reset zeroes all counters
// - event reset leaves event overflow flags alone
// - global enable gates counters below span
// - span is limit with hyp, else count
// - accessed via coprocessor 15 at 9/12, opcodes 0
// - user access traps undefined without enable
// - lower-level access traps to hyp on trap bits
// - read-only part code in bits 23:16
// - maker code in top byte, zero hides part
// - warm reset domain, low seven bits debug-shared
`timescale 1ns/10ps
module pmc_ctrl
(
    input  wire logic                              clock,
    input  wire logic                              rstn,
    // coprocessor access
    input  wire logic                              acc_valid,
    input  wire logic                              acc_write,
    input  wire logic [3:0]                        acc_coproc,
    input  wire logic [2:0]                        acc_opc1,
    input  wire logic [3:0]                        acc_crn,
    input  wire logic [3:0]                        acc_crm,
    input  wire logic [2:0]                        acc_opc2,
    input  wire logic [1:0]                        acc_level,
    input  wire logic [31:0]                       acc_wdata,
    output logic                                   acc_done,
    output logic [1:0]                             acc_answer,
    output logic [31:0]                            acc_rdata,
    // debug view of the low seven bits
    input  wire logic                              dbg_write,
    input  wire logic [6:0]                        dbg_wdata,
    output logic [6:0]                             dbg_rdata,
    // controls from neighbouring registers
    input  wire logic                              hyp_enabled,
    input  wire logic [4:0]                        hyp_counter_limit,
    input  wire logic                              user_access_enable,
    input  wire logic                              hyp_perf_trap,
    input  wire logic                              hyp_ctrl_reg_trap,
    input  wire logic                              primary_reg9_trap,
    input  wire logic [31:0]                       counter_enable_set_reg,
    input  wire logic                              count_prohibited,
    input  wire logic [30:0]                       event_in,
    // results
    output logic [63:0]                            cycle_tally,
    output logic                                   cycle_ovf,
    output logic [30:0]                            event_ovf,
    output logic [30:0]                            export_events
);
    // ----------------------------------------
    // control bits
    // ----------------------------------------
    logic       enable_reg;
    logic       divider_reg;
    logic       export_reg;
    logic       prohibit_reg;
    logic       wide_reg;

    // cycle tally and sticky flags
    logic [63:0] cyc_reg;
    logic        cyc_ovf_reg;
    logic [30:0] evt_ovf_reg;

    // answer and export stages
    logic [30:0] export_reg_q;
    logic        done_reg;
    logic [1:0]  answer_reg;
    logic [31:0] rdata_reg;

    // ----------------------------------------
    // access decode and traps
    // ----------------------------------------
    wire hit = acc_valid && acc_coproc == pmc_pkg::COPROC_NUM && acc_opc1 == pmc_pkg::OPC1_VAL
               && acc_crn == pmc_pkg::PRIMARY_VAL && acc_crm == pmc_pkg::SECONDARY_VAL
               && acc_opc2 == pmc_pkg::OPC2_VAL;
    wire is_user  = acc_level == pmc_pkg::PMC_PL_USER;
    wire is_hyp   = acc_level == pmc_pkg::PMC_PL_HYP;
    wire trap_und = hit && is_user && !user_access_enable;
    wire trap_hyp = hit && !is_hyp && pmc_pkg::HAS_HYP
                    && (hyp_perf_trap || hyp_ctrl_reg_trap || primary_reg9_trap);
    wire ok       = hit && !trap_und && !trap_hyp;
    wire wr       = ok && acc_write;
    // undefined is judged before hyp, and a trapped write changes nothing
    wire [1:0] answer = trap_und ? pmc_pkg::PMC_ANS_UNDEF :
                        trap_hyp ? pmc_pkg::PMC_ANS_HYP : pmc_pkg::PMC_ANS_OK;

    // ----------------------------------------
    // span and count view
    // ----------------------------------------
    // lower levels see the limit as the count, so a guest only sees its share
    wire [4:0] span = pmc_pkg::HAS_HYP ? hyp_counter_limit : pmc_pkg::NUM_COUNTERS;
    wire [4:0] count_view = (pmc_pkg::HAS_HYP && !is_hyp) ? hyp_counter_limit
                                                          : pmc_pkg::NUM_COUNTERS;
    wire [7:0] part_view = (pmc_pkg::MAKER_CODE == 8'h00) ? 8'h00 : pmc_pkg::PART_CODE;
    wire [6:0] low_bits  = {wide_reg, prohibit_reg, export_reg, divider_reg, 1'b0, 1'b0, enable_reg};
    wire [31:0] rd_word  = {pmc_pkg::MAKER_CODE, part_view, count_view, 4'h0, low_bits};

    // ----------------------------------------
    // reset strobes
    // ----------------------------------------
    // event reset reach depends on the level of the writer
    wire       cyc_clear = wr && acc_wdata[pmc_pkg::CYC_RESET_BIT];
    wire       evt_clear = wr && acc_wdata[pmc_pkg::EVT_RESET_BIT];
    wire [4:0] clear_lim = (is_hyp || !hyp_enabled || !pmc_pkg::HAS_HYP
                            || hyp_counter_limit >= pmc_pkg::NUM_COUNTERS)
                           ? pmc_pkg::NUM_COUNTERS : hyp_counter_limit;

    // ----------------------------------------
    // cycle tally
    // ----------------------------------------
    // the divider only steps while the tally runs, so a pause keeps its phase
    wire cyc_stop  = prohibit_reg && count_prohibited;
    wire cyc_run   = enable_reg && counter_enable_set_reg[31] && !cyc_stop;
    wire div_tick;
    wire cyc_adv   = cyc_run && ((divider_reg && !wide_reg) ? div_tick : 1'b1);
    wire [64:0] cyc_sum = {1'b0, cyc_reg} + 65'h1;
    // in 32-bit mode the flag watches the low word only; the tally keeps 64 bits
    wire cyc_wrap  = wide_reg ? cyc_sum[64] : (cyc_reg[31:0] == 32'hffffffff);

    pmc_div u_div
    (
        .clock (clock),
        .rstn  (rstn),
        .run   (cyc_run),
        .tick  (div_tick)
    );

    // ----------------------------------------
    // event counters
    // ----------------------------------------
    // slots past the implemented count are tied off so every flag bit has a driver
    wire [30:0] ovf_pulse;
    genvar g;
    generate
        for (g = 0; g < pmc_pkg::MAX_COUNTERS; g++)
        begin : g_evt
            pmc_cnt_if port_i ();
            if (g < int'(pmc_pkg::NUM_COUNTERS))
            begin : g_impl
                wire below = 5'(g) < span;
                // global enable only governs counters below the span
                assign port_i.advance = event_in[g] && counter_enable_set_reg[g]
                                        && (!below || enable_reg);
                assign port_i.clear   = evt_clear && (5'(g) < clear_lim);
                assign port_i.wide    = 1'b0;
                pmc_event_cnt u_cnt
                (
                    .clock  (clock),
                    .rstn   (rstn),
                    .port_c (port_i.cnt)
                );
            end
            else
            begin : g_none
                assign port_i.advance   = 1'b0;
                assign port_i.clear     = 1'b0;
                assign port_i.wide      = 1'b0;
                assign port_i.value     = '0;
                assign port_i.ovf_pulse = 1'b0;
            end
            assign ovf_pulse[g] = port_i.ovf_pulse;
        end
    endgenerate

    // export: gated by bit and prohibition, independent of overflow logic
    wire [30:0] export_next = (export_reg && !count_prohibited) ? event_in : 31'h0;

    // ----------------------------------------
    // control bit loading
    // ----------------------------------------
    // an access write wins over a debug write landing in the same cycle
    wire       ctrl_load = wr || dbg_write;
    wire [6:0] ctrl_src  = wr ? acc_wdata[6:0] : dbg_wdata;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            enable_reg <= 1'b0;
        else if (ctrl_load)
            enable_reg <= ctrl_src[pmc_pkg::ENABLE_BIT];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            divider_reg <= 1'b0;
        else if (ctrl_load)
            divider_reg <= ctrl_src[pmc_pkg::DIVIDER_BIT];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            export_reg <= 1'b0;
        else if (ctrl_load)
            export_reg <= ctrl_src[pmc_pkg::EXPORT_BIT] && pmc_pkg::HAS_EXPORT_BUS;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            prohibit_reg <= 1'b0;
        else if (ctrl_load)
            prohibit_reg <= ctrl_src[pmc_pkg::PROHIBIT_BIT];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            wide_reg <= pmc_pkg::WIDE_OVF_RST;
        else if (ctrl_load)
            wide_reg <= ctrl_src[pmc_pkg::WIDE_OVF_BIT];
    end

    // ----------------------------------------
    // cycle tally state and flags
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cyc_reg <= 64'h0;
        else if (cyc_clear)
            cyc_reg <= 64'h0;
        else if (cyc_adv)
            cyc_reg <= cyc_sum[63:0];
    end

    // the strobe only zeroes the tally; the sticky flag stays for software to read
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cyc_ovf_reg <= 1'b0;
        else if (cyc_adv && !cyc_clear && cyc_wrap)
            cyc_ovf_reg <= 1'b1;
    end

    // flags are only ever set here; the event reset strobe has no path to them
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            evt_ovf_reg <= 31'h0;
        else
            evt_ovf_reg <= evt_ovf_reg | ovf_pulse;
    end

    // ----------------------------------------
    // access answer and export stage
    // ----------------------------------------
    // read data is zero on writes and traps so nothing leaks past a trap
    wire [31:0] rdata_next = (ok && !acc_write) ? rd_word : 32'h0;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            done_reg   <= 1'b0;
            answer_reg <= pmc_pkg::PMC_ANS_OK;
            rdata_reg  <= 32'h0;
        end
        else
        begin
            done_reg   <= hit;
            answer_reg <= answer;
            rdata_reg  <= rdata_next;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            export_reg_q <= 31'h0;
        else
            export_reg_q <= export_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // debug view reads the same flops, with both strobe bits fixed at zero
    assign acc_done      = done_reg;
    assign acc_answer    = answer_reg;
    assign acc_rdata     = rdata_reg;
    assign dbg_rdata     = low_bits;
    assign cycle_tally   = cyc_reg;
    assign cycle_ovf     = cyc_ovf_reg;
    assign event_ovf     = evt_ovf_reg;
    assign export_events = export_reg_q;
endmodule // pmc_ctrl

/* File: design/pmc_pkg.sv */
// package with constants and types for the perf monitor control block
package pmc_pkg;
    // ----------------------------------------
    // field positions of perf_monitor_control
    // ----------------------------------------
    localparam int          ENABLE_BIT     = 0;
    localparam int          EVT_RESET_BIT  = 1;
    localparam int          CYC_RESET_BIT  = 2;
    localparam int          DIVIDER_BIT    = 3;
    localparam int          EXPORT_BIT     = 4;
    localparam int          PROHIBIT_BIT   = 5;
    localparam int          WIDE_OVF_BIT   = 6;
    localparam int          COUNT_LSB      = 11;
    localparam int          PART_LSB       = 16;
    localparam int          MAKER_LSB      = 24;
    // ----------------------------------------
    // access encoding
    // ----------------------------------------
    localparam logic [3:0]  COPROC_NUM     = 4'hf;
    localparam logic [2:0]  OPC1_VAL       = 3'h0;
    localparam logic [3:0]  PRIMARY_VAL    = 4'h9;
    localparam logic [3:0]  SECONDARY_VAL  = 4'hc;
    localparam logic [2:0]  OPC2_VAL       = 3'h0;
    // ----------------------------------------
    // implementation values and timing
    // ----------------------------------------
    localparam logic [4:0]  NUM_COUNTERS   = 5'h06;
    localparam int          MAX_COUNTERS   = 31;
    localparam logic [7:0]  MAKER_CODE     = 8'h5a;  // arbitrary value
    localparam logic [7:0]  PART_CODE      = 8'h3c;  // arbitrary value
    localparam logic        HAS_HYP        = 1'b1;
    localparam logic        HAS_EXPORT_BUS = 1'b1;
    localparam logic        WIDE_OVF_RST   = 1'b1;
    localparam int          DIV_CYCLES     = 64;
    localparam int          CNT_WIDTH      = 32;
    localparam int          CYC_WIDTH      = 64;
    // ----------------------------------------
    // privilege levels and answers
    // ----------------------------------------
    typedef enum logic [1:0] {
        PMC_PL_USER = 2'h0,
        PMC_PL_KERN = 2'h1,
        PMC_PL_HYP  = 2'h2
    } pmc_level_t;
    typedef enum logic [1:0] {
        PMC_ANS_OK    = 2'h0,
        PMC_ANS_UNDEF = 2'h1,
        PMC_ANS_HYP   = 2'h3
    } pmc_answer_t;
endpackage : pmc_pkg

/* File: design/pmc_cnt_if.sv */
// interface carrying counter controls between the control block and its counters
`timescale 1ns/10ps
interface pmc_cnt_if;
    logic                                advance;
    logic                                clear;
    logic                                wide;
    logic [pmc_pkg::CNT_WIDTH-1:0]       value;
    logic                                ovf_pulse;
    modport ctrl (output advance, output clear, output wide, input value, input ovf_pulse);
    modport cnt  (input advance, input clear, input wide, output value, output ovf_pulse);
endinterface : pmc_cnt_if

/* File: design/pmc_div.sv */
// divide-by-64 prescaler producing a one-cycle enable for the cycle tally
`timescale 1ns/10ps
module pmc_div
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic run,
    output logic      tick
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;

    assign cnt_next = cnt_reg + 6'h01;
    assign tick     = run && (cnt_reg == 6'(pmc_pkg::DIV_CYCLES - 1));

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= 6'h00;
        else if (run)
            cnt_reg <= cnt_next;
    end
endmodule // pmc_div

/* File: design/pmc_event_cnt.sv */
// one event counter with enable, clear strobe and overflow pulse
`timescale 1ns/10ps
module pmc_event_cnt
(
    input  wire logic clock,
    input  wire logic rstn,
    pmc_cnt_if.cnt    port_c
);
    logic [pmc_pkg::CNT_WIDTH-1:0] cnt_reg;
    logic [pmc_pkg::CNT_WIDTH:0]   sum;
    logic                          ovf_reg;

    assign sum              = {1'b0, cnt_reg} + 33'h1;
    assign port_c.value     = cnt_reg;
    assign port_c.ovf_pulse = ovf_reg;

    // clear has priority; overflow flags live elsewhere and are never touched by it
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg <= '0;
            ovf_reg <= 1'b0;
        end
        else
        begin
            ovf_reg <= port_c.advance && !port_c.clear && sum[pmc_pkg::CNT_WIDTH];
            if (port_c.clear)
                cnt_reg <= '0;
            else if (port_c.advance)
                cnt_reg <= sum[pmc_pkg::CNT_WIDTH-1:0];
        end
    end
endmodule // pmc_event_cnt

/* File: tb/pmc_ctrl_checker.sv */
// port-level assertions for the perf monitor control block
`timescale 1ns/10ps
module pmc_ctrl_checker
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [3:0]  acc_coproc,
    input wire logic [2:0]  acc_opc1,
    input wire logic [3:0]  acc_crn,
    input wire logic [3:0]  acc_crm,
    input wire logic [2:0]  acc_opc2,
    input wire logic [1:0]  acc_level,
    input wire logic [31:0] acc_wdata,
    input wire logic        acc_done,
    input wire logic [1:0]  acc_answer,
    input wire logic [31:0] acc_rdata,
    input wire logic [6:0]  dbg_rdata,
    input wire logic [4:0]  hyp_counter_limit,
    input wire logic        user_access_enable,
    input wire logic        hyp_perf_trap,
    input wire logic        hyp_ctrl_reg_trap,
    input wire logic        primary_reg9_trap,
    input wire logic [31:0] counter_enable_set_reg,
    input wire logic        count_prohibited,
    input wire logic [63:0] cycle_tally,
    input wire logic        cycle_ovf,
    input wire logic [30:0] export_events
);
    // ------------------------------
    // decode helpers
    // ------------------------------
    wire hit = acc_valid && acc_coproc == pmc_pkg::COPROC_NUM && acc_opc1 == pmc_pkg::OPC1_VAL
        && acc_crn == pmc_pkg::PRIMARY_VAL && acc_crm == pmc_pkg::SECONDARY_VAL && acc_opc2 == pmc_pkg::OPC2_VAL;
    wire traps = hyp_perf_trap || hyp_ctrl_reg_trap || primary_reg9_trap;
    wire rd_hyp = hit && !acc_write && acc_level == 2'h2;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ------------------------------
    // assertions
    // ------------------------------
    chk_done_on_hit: assert property (hit |=> acc_done) else $error("no done");
    chk_miss_quiet: assert property (!hit |=> !acc_done) else $error("stray done");
    chk_user_undef: assert property (hit && acc_level == 2'h0 && !user_access_enable |=> acc_answer == 2'h1)
        else $error("user trap");
    chk_hyp_trap: assert property (hit && acc_level == 2'h1 && traps |=> acc_answer == 2'h3)
        else $error("hyp trap");
    chk_read_ident: assert property (rd_hyp |=> acc_rdata[31:7] == {pmc_pkg::MAKER_CODE, pmc_pkg::PART_CODE,
        pmc_pkg::NUM_COUNTERS, 4'h0} && acc_rdata[2:1] == 2'h0) else $error("id read");
    chk_read_limit: assert property (hit && !acc_write && acc_level == 2'h1 && !traps
        |=> acc_rdata[15:11] == $past(hyp_counter_limit)) else $error("limit read");
    chk_strobe_clear: assert property (hit && acc_write && acc_level == 2'h2 && acc_wdata[2]
        |=> cycle_tally == 64'h0) else $error("tally clear");
    chk_ovf_sticky: assert property (cycle_ovf |=> cycle_ovf) else $error("ovf lost");
    chk_stop_off: assert property (!dbg_rdata[0] && !acc_valid |=> $stable(cycle_tally))
        else $error("tally ran");
    chk_wide_step: assert property (dbg_rdata[6] && dbg_rdata[0] && counter_enable_set_reg[31]
        && !count_prohibited && !acc_valid |=> cycle_tally == $past(cycle_tally) + 64'h1)
        else $error("tally step");
    chk_export_gate: assert property (count_prohibited && $past(count_prohibited) |-> export_events == 31'h0)
        else $error("export leak");
endmodule // pmc_ctrl_checker

bind pmc_ctrl pmc_ctrl_checker u_chk (.clock(clock), .rstn(rstn), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_coproc(acc_coproc), .acc_opc1(acc_opc1), .acc_crn(acc_crn),
    .acc_crm(acc_crm), .acc_opc2(acc_opc2), .acc_level(acc_level), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_answer(acc_answer), .acc_rdata(acc_rdata), .dbg_rdata(dbg_rdata),
    .hyp_counter_limit(hyp_counter_limit), .user_access_enable(user_access_enable),
    .hyp_perf_trap(hyp_perf_trap), .hyp_ctrl_reg_trap(hyp_ctrl_reg_trap),
    .primary_reg9_trap(primary_reg9_trap), .counter_enable_set_reg(counter_enable_set_reg),
    .count_prohibited(count_prohibited), .cycle_tally(cycle_tally), .cycle_ovf(cycle_ovf),
    .export_events(export_events));

/* File: tb/pmc_ctrl_tb.sv */
// self-checking bench for the perf monitor control block
`timescale 1ns/10ps
module pmc_ctrl_tb;
    logic        clock = 1'b0, rstn = 1'b0, acc_valid = 1'b0, acc_write = 1'b0, dbg_write = 1'b0;
    logic [3:0]  acc_coproc = pmc_pkg::COPROC_NUM, acc_crn = pmc_pkg::PRIMARY_VAL;
    logic [3:0]  acc_crm = pmc_pkg::SECONDARY_VAL;
    logic [2:0]  acc_opc1 = pmc_pkg::OPC1_VAL, acc_opc2 = pmc_pkg::OPC2_VAL;
    logic [1:0]  acc_level = 2'h2;
    logic [31:0] acc_wdata = 32'h0, counter_enable_set_reg = 32'h8000_0000;
    logic [6:0]  dbg_wdata = 7'h0;
    logic [4:0]  hyp_counter_limit = 5'h03;
    logic        hyp_enabled = 1'b1, user_access_enable = 1'b0, count_prohibited = 1'b0;
    logic        hyp_perf_trap = 1'b0, hyp_ctrl_reg_trap = 1'b0, primary_reg9_trap = 1'b0;
    logic [30:0] event_in = 31'h0;
    logic        acc_done, cycle_ovf, got_done;
    logic [1:0]  acc_answer, got_ans;
    logic [31:0] acc_rdata, got_rd;
    logic [6:0]  dbg_rdata;
    logic [63:0] cycle_tally, got_tally, diff;
    logic [30:0] event_ovf, export_events;
    int          mismatches = 0;
    int          samples_checked = 0;
    // fixed bits 31:11 of every read at hyp level
    localparam logic [31:0] ID = {pmc_pkg::MAKER_CODE, pmc_pkg::PART_CODE, pmc_pkg::NUM_COUNTERS, 11'h0};

    always #10 clock = ~clock;

    pmc_ctrl dut (.*);

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // answer is registered on the taking edge, so sample just after it
    task automatic acc(input logic [1:0] lv, input logic wr, input logic [31:0] wd);
        @(posedge clock);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_level <= lv;
        acc_wdata <= wd;
        @(posedge clock);
        acc_valid <= 1'b0;
        #1;
        got_done = acc_done;
        got_ans = acc_answer;
        got_rd = acc_rdata;
        got_tally = cycle_tally;
    endtask

    task automatic rate(input int n);
        logic [63:0] t0;
        @(posedge clock);
        #1 t0 = cycle_tally;
        repeat (n) @(posedge clock);
        #1 diff = cycle_tally - t0;
    endtask

    task automatic pulse(input logic [30:0] ev);
        @(posedge clock);
        event_in <= ev;
        @(posedge clock);
        event_in <= 31'h0;
        #1;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        acc(2'h2, 1'b0, 32'h0);
        chk(got_done, 1'b1);
        chk(got_rd, ID | 32'h40);
        chk(dbg_rdata, 7'h40);
    endtask

    task automatic t_levels();
        acc(2'h0, 1'b0, 32'h0);
        chk(got_ans, 2'h1);
        @(posedge clock) user_access_enable <= 1'b1;
        acc(2'h0, 1'b0, 32'h0);
        chk({got_ans, got_rd[15:11]}, {2'h0, 5'h03});
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock) {hyp_perf_trap, hyp_ctrl_reg_trap, primary_reg9_trap} <= 3'h1 << i;
            acc(2'h1, 1'b1, 32'h1);
            chk(got_ans, 2'h3);
            acc(2'h2, 1'b0, 32'h0);
            chk({got_ans, got_rd[0]}, 3'h0);
        end
        @(posedge clock) {hyp_perf_trap, hyp_ctrl_reg_trap, primary_reg9_trap} <= 3'h0;
        acc(2'h1, 1'b0, 32'h0);
        chk({got_ans, got_rd[15:11]}, {2'h0, 5'h03});
    endtask

    task automatic t_decode();
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clock);
            acc_coproc <= pmc_pkg::COPROC_NUM ^ {3'h0, k == 0};
            acc_opc1 <= pmc_pkg::OPC1_VAL ^ {2'h0, k == 1};
            acc_crn <= pmc_pkg::PRIMARY_VAL ^ {3'h0, k == 2};
            acc_crm <= pmc_pkg::SECONDARY_VAL ^ {3'h0, k == 3};
            acc_opc2 <= pmc_pkg::OPC2_VAL ^ {2'h0, k == 4};
            acc(2'h2, 1'b1, 32'h0);
            chk(got_done, k == 5);
        end
    endtask

    task automatic t_readback();
        acc(2'h2, 1'b1, 32'hffff_ffff);
        acc(2'h2, 1'b0, 32'h0);
        chk(got_rd, ID | 32'h79);
        chk(dbg_rdata, 7'h79);
        @(posedge clock);
        dbg_write <= 1'b1;
        dbg_wdata <= 7'h46;
        @(posedge clock) dbg_write <= 1'b0;
        acc(2'h2, 1'b0, 32'h0);
        chk(got_rd, ID | 32'h40);
    endtask

    task automatic t_rate();
        acc(2'h2, 1'b1, 32'h9);
        rate(64);
        chk(diff, 64'h1);
        acc(2'h2, 1'b1, 32'h49);
        rate(10);
        chk(diff, 64'ha);
        acc(2'h2, 1'b1, 32'h5);
        chk(got_tally, 64'h0);
        rate(10);
        chk(diff, 64'ha);
    endtask

    task automatic t_stop();
        acc(2'h2, 1'b1, 32'h21);
        @(posedge clock) count_prohibited <= 1'b1;
        rate(10);
        chk(diff, 64'h0);
        acc(2'h2, 1'b1, 32'h1);
        rate(10);
        chk(diff, 64'ha);
        @(posedge clock) count_prohibited <= 1'b0;
        acc(2'h2, 1'b1, 32'h0);
        rate(10);
        chk(diff, 64'h0);
        acc(2'h2, 1'b1, 32'h1);
        @(posedge clock) counter_enable_set_reg <= 32'h0;
        rate(10);
        chk(diff, 64'h0);
    endtask

    task automatic t_export();
        acc(2'h2, 1'b1, 32'h10);
        pulse(31'h15);
        chk(export_events, 31'h15);
        @(posedge clock) count_prohibited <= 1'b1;
        pulse(31'h15);
        chk(export_events, 31'h0);
        @(posedge clock) count_prohibited <= 1'b0;
        acc(2'h2, 1'b1, 32'h0);
        pulse(31'h15);
        chk(export_events, 31'h0);
        chk({cycle_ovf, event_ovf}, 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_levels();
        t_decode();
        t_readback();
        t_rate();
        t_stop();
        t_export();
        finish_test();
    end
endmodule // pmc_ctrl_tb
